// *** rtl/ptk_regs.svh ***
// Register map, field positions and reset values of the periodic tick and modulation control
`ifndef PTK_REGS_SVH
`define PTK_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PTK_IDX_MOD        6'h0A
`define PTK_IDX_RATE       6'h0B
`define PTK_IDX_CTRL       6'h10
`define PTK_IDX_STAT       6'h11
`define PTK_IDX_INT_STAT   6'h12
`define PTK_IDX_INT_MASK   6'h13

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PTK_MOD_LO         4
`define PTK_MOD_HI         5
`define PTK_RATE_STYLE     7
`define PTK_RATE_PRE_HI    6
`define PTK_RATE_PRE_LO    4
`define PTK_RATE_MOD_HI    3
`define PTK_RATE_MOD_LO    0
`define PTK_CTRL_SRC       0
`define PTK_CTRL_PSTOP     1
`define PTK_CTRL_GUARD     2
`define PTK_CTRL_LOOP      3
`define PTK_STAT_LOCK      0
`define PTK_STAT_READY     1
`define PTK_INT_TICK       0

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define PTK_MOD_RST        2'h0
`define PTK_RATE_RST       8'h00
`define PTK_CTRL_RST       4'h0
`define PTK_FM_DIV         4'hF
`define PTK_BIN_BASE       22'h000400
`define PTK_DEC_1K         22'h0003E8
`define PTK_DEC_2K         22'h0007D0
`define PTK_DEC_5K         22'h001388
`define PTK_DEC_10K        22'h002710
`define PTK_DEC_20K        22'h004E20
`define PTK_DEC_50K        22'h00C350
`define PTK_DEC_100K       22'h0186A0
`define PTK_DEC_200K       22'h030D40

`endif

// *** rtl/ptk_pkg.sv ***
// Shared types of the periodic tick and modulation control block
package ptk_pkg;
	typedef enum logic [0:0] {
		PTK_STYLE_BIN = 1'b0,
		PTK_STYLE_DEC = 1'b1
	} ptk_style_t;
	typedef logic [21:0] ptk_period_t;
endpackage

// *** rtl/ptk_period_decode.sv ***
// Decodes the tick rate register into a period in source clocks
`timescale 1ns/1ps
`include "ptk_regs.svh"

module ptk_period_decode (
	input  wire logic                 style_i,   // Divider style, 1 = decimal
	input  wire logic [2:0]           pre_i,     // Prescale code
	input  wire logic [3:0]           modsel_i,  // Modulus code
	output ptk_pkg::ptk_period_t      period_o,  // Period in source clocks
	output logic                      enable_o   // Tick runs
);
	// ----------------------------------------------------------------
	// Prescale lookup
	// ----------------------------------------------------------------
	function automatic ptk_pkg::ptk_period_t dec_pre(input logic [2:0] code);
		case (code)
			3'h0: dec_pre = `PTK_DEC_1K;
			3'h1: dec_pre = `PTK_DEC_2K;
			3'h2: dec_pre = `PTK_DEC_5K;
			3'h3: dec_pre = `PTK_DEC_10K;
			3'h4: dec_pre = `PTK_DEC_20K;
			3'h5: dec_pre = `PTK_DEC_50K;
			3'h6: dec_pre = `PTK_DEC_100K;
			default: dec_pre = `PTK_DEC_200K;
		endcase
	endfunction

	ptk_pkg::ptk_period_t pre_val;
	logic [26:0]          product;

	// Binary doubles per code from the base, decimal uses the table
	always_comb begin
		if (style_i == ptk_pkg::PTK_STYLE_DEC) begin
			pre_val  = dec_pre(pre_i);
			enable_o = 1'b1;
		end else begin
			pre_val  = (pre_i == 3'h0) ? `PTK_BIN_BASE : (`PTK_BIN_BASE << (pre_i - 3'h1));
			enable_o = (pre_i != 3'h0);
		end
		product  = pre_val * ({1'b0, modsel_i} + 5'h01);
		period_o = product[21:0];
	end
endmodule // ptk_period_decode

// *** rtl/ptk_tick_counter.sv ***
// Modulus counter producing the periodic tick from source clock edges
`timescale 1ns/1ps

module ptk_tick_counter #(
	parameter int W = 22                     // Counter width
) (
	input  wire logic         mclk_i,         // System clock
	input  wire logic         reset_n_i,      // Synchronous reset, active low
	input  wire logic         src_edge_i,     // One pulse per source clock edge
	input  wire logic         run_i,          // Counting allowed
	input  wire logic         enable_i,       // Tick enabled
	input  wire logic         restart_i,      // Start a new period
	input  wire logic [W-1:0] period_i,       // Period in source clocks
	output logic     [W-1:0]  count_o,        // Current count
	output logic              tick_o          // One-cycle tick event
);
	// Restart wins; a frozen counter keeps its value
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			count_o <= '0;
			tick_o  <= 1'b0;
		end else if (restart_i || !enable_i) begin
			count_o <= '0;
			tick_o  <= 1'b0;
		end else if (run_i && src_edge_i) begin
			if (count_o >= period_i - W'(1)) begin
				count_o <= '0;
				tick_o  <= 1'b1;
			end else begin
				count_o <= count_o + W'(1);
				tick_o  <= 1'b0;
			end
		end else begin
			tick_o <= 1'b0;
		end
	end
endmodule // ptk_tick_counter

// *** rtl/ptk_top.sv ***
// Periodic tick and loop modulation control with APB register access
// Function
// - Modulation register at index 0x0A, 8 bits, only bits 5:4 exist, reset zero
// - Modulation write accepted only with protect clear and loop select set
// - Accepted modulation write clears lock and crystal ready flags
// - Amplitude code 00 off, 01 one, 10 two, 11 four percent
// - Modulation rate is reference frequency divided by sixteen
// - Tick source is RC clock when select is 0, crystal when 1
// - In stop, tick runs only with pseudo-stop and crystal source
// - Tick rate register at index 0x0B, 8 bits, reset zero, always writable
// - Every tick rate write restarts the period
// - Any change of tick source select restarts the period
// - Bit 7 selects binary or decimal prescale style
// - Binary codes 001 to 111 select two to the ten through sixteen
// - Modulus field multiplies the prescaler by value plus one
// - Binary code 000 disables the tick regardless of modulus
// - Decimal codes select 1k to 200k times modulus, never off
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "ptk_regs.svh"

module ptk_top #(
	parameter int CW = 22                       // Tick counter width
) (
	input  wire logic        mclk_i,             // 40 MHz system clock
	input  wire logic        reset_n_i,          // Synchronous reset, active low
	input  wire logic        psel_i,             // APB select
	input  wire logic        penable_i,          // APB enable
	input  wire logic        pwrite_i,           // APB write
	input  wire logic [7:0]  paddr_i,            // APB byte address
	input  wire logic [31:0] pwdata_i,           // APB write data
	output logic      [31:0] prdata_o,           // APB read data
	output logic             pready_o,           // APB ready
	output logic             pslverr_o,          // APB error on unmapped address
	input  wire logic        irc_edge_i,         // Internal RC clock edge pulse
	input  wire logic        xtal_edge_i,        // Crystal clock edge pulse
	input  wire logic        ref_edge_i,         // Loop reference edge pulse
	input  wire logic        stop_mode_i,        // Stop mode active
	input  wire logic        lock_acquired_i,    // Loop lock event
	input  wire logic        crystal_up_i,       // Crystal became ready
	input  wire logic        crystal_lost_i,     // Crystal ready lost
	output logic      [1:0]  mod_amplitude_o,    // Modulation amplitude code
	output logic             fm_step_o,          // Modulation rate pulse
	output logic             tick_o,             // Periodic tick pulse
	output logic             irq_o,              // Interrupt, level
	output logic             loop_locked_o,      // Loop lock flag
	output logic             crystal_ready_flag_o // Crystal ready flag
);
	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic addr_is(input logic [7:0] a, input logic [5:0] idx);
		addr_is = (a[7:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	logic       access;
	logic       wr_en;
	logic       hit_mod, hit_rate, hit_ctrl, hit_stat, hit_ist, hit_imsk, mapped;
	logic       mod_accept;

	assign access   = psel_i && penable_i && pready_o;
	assign wr_en    = access && pwrite_i && !pslverr_o;
	assign hit_mod  = addr_is(paddr_i, `PTK_IDX_MOD);
	assign hit_rate = addr_is(paddr_i, `PTK_IDX_RATE);
	assign hit_ctrl = addr_is(paddr_i, `PTK_IDX_CTRL);
	assign hit_stat = addr_is(paddr_i, `PTK_IDX_STAT);
	assign hit_ist  = addr_is(paddr_i, `PTK_IDX_INT_STAT);
	assign hit_imsk = addr_is(paddr_i, `PTK_IDX_INT_MASK);
	assign mapped   = hit_mod | hit_rate | hit_ctrl | hit_stat | hit_ist | hit_imsk;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [1:0] mod_r;
	logic [7:0] rate_r;
	logic [3:0] ctrl_r;
	logic       int_stat_r;
	logic       int_mask_r;
	logic       src_prev_r;
	logic [3:0] fm_cnt_r;
	logic       tick_ev;
	logic [CW-1:0] count;
	ptk_pkg::ptk_period_t period;
	logic       period_en;
	logic       restart;
	logic       run;
	logic       src_sel;

	assign src_sel    = ctrl_r[`PTK_CTRL_SRC];
	assign mod_accept = wr_en && hit_mod && !ctrl_r[`PTK_CTRL_GUARD]
		&& ctrl_r[`PTK_CTRL_LOOP];

	// APB answer: one wait cycle, data and error registered with ready
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o  <= psel_i && penable_i && !pready_o;
			pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
			prdata_o  <= 32'h0000_0000;
			if (psel_i && penable_i && !pready_o && !pwrite_i) begin
				if (hit_mod)
					prdata_o[`PTK_MOD_HI:`PTK_MOD_LO] <= mod_r;
				if (hit_rate)
					prdata_o[7:0] <= rate_r;
				if (hit_ctrl)
					prdata_o[3:0] <= ctrl_r;
				if (hit_stat) begin
					prdata_o[`PTK_STAT_LOCK]  <= loop_locked_o;
					prdata_o[`PTK_STAT_READY] <= crystal_ready_flag_o;
				end
				if (hit_ist)
					prdata_o[`PTK_INT_TICK] <= int_stat_r;
				if (hit_imsk)
					prdata_o[`PTK_INT_TICK] <= int_mask_r;
			end
		end
	end

	// Modulation amplitude, write-gated
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			mod_r <= `PTK_MOD_RST;
		else if (mod_accept)
			mod_r <= pwdata_i[`PTK_MOD_HI:`PTK_MOD_LO];
	end

	// Tick rate register, writable at any time
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			rate_r <= `PTK_RATE_RST;
		else if (wr_en && hit_rate)
			rate_r <= pwdata_i[7:0];
	end

	// Control bits; source select only sets while the crystal is ready
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			ctrl_r <= `PTK_CTRL_RST;
		end else begin
			if (wr_en && hit_ctrl) begin
				ctrl_r[`PTK_CTRL_PSTOP] <= pwdata_i[`PTK_CTRL_PSTOP];
				ctrl_r[`PTK_CTRL_GUARD] <= pwdata_i[`PTK_CTRL_GUARD];
				ctrl_r[`PTK_CTRL_LOOP]  <= pwdata_i[`PTK_CTRL_LOOP];
			end
			if (!crystal_ready_flag_o)
				ctrl_r[`PTK_CTRL_SRC] <= 1'b0;
			else if (wr_en && hit_ctrl)
				ctrl_r[`PTK_CTRL_SRC] <= pwdata_i[`PTK_CTRL_SRC];
		end
	end

	// Lock flag: an arriving lock event wins over the clear
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			loop_locked_o <= 1'b0;
		else if (lock_acquired_i)
			loop_locked_o <= 1'b1;
		else if (mod_accept)
			loop_locked_o <= 1'b0;
	end

	// Crystal ready flag: set wins over the clear
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			crystal_ready_flag_o <= 1'b0;
		else if (crystal_up_i)
			crystal_ready_flag_o <= 1'b1;
		else if (mod_accept || crystal_lost_i)
			crystal_ready_flag_o <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Frequency modulation
	// ----------------------------------------------------------------
	// Amplitude code drives the oscillator directly; 00 means off
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			mod_amplitude_o <= `PTK_MOD_RST;
		else
			mod_amplitude_o <= mod_r;
	end

	// One step per sixteen reference edges, held idle while off
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			fm_cnt_r  <= 4'h0;
			fm_step_o <= 1'b0;
		end else if (mod_r == 2'h0) begin
			fm_cnt_r  <= 4'h0;
			fm_step_o <= 1'b0;
		end else if (ref_edge_i) begin
			fm_cnt_r  <= fm_cnt_r + 4'h1;
			fm_step_o <= (fm_cnt_r == `PTK_FM_DIV);
		end else begin
			fm_step_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Periodic tick
	// ----------------------------------------------------------------
	// Previous source select, to spot a change from any cause
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			src_prev_r <= 1'b0;
		else
			src_prev_r <= src_sel;
	end

	assign restart = (wr_en && hit_rate) || (src_sel != src_prev_r);
	// Freezing keeps the count so the period resumes after stop
	assign run = !stop_mode_i || (ctrl_r[`PTK_CTRL_PSTOP] && src_sel);

	ptk_period_decode u_decode (
		.style_i  (rate_r[`PTK_RATE_STYLE]),
		.pre_i    (rate_r[`PTK_RATE_PRE_HI:`PTK_RATE_PRE_LO]),
		.modsel_i (rate_r[`PTK_RATE_MOD_HI:`PTK_RATE_MOD_LO]),
		.period_o (period),
		.enable_o (period_en)
	);

	ptk_tick_counter #(.W(CW)) u_counter (
		.mclk_i     (mclk_i),
		.reset_n_i  (reset_n_i),
		.src_edge_i (src_sel ? xtal_edge_i : irc_edge_i),
		.run_i      (run),
		.enable_i   (period_en),
		.restart_i  (restart),
		.period_i   (period),
		.count_o    (count),
		.tick_o     (tick_ev)
	);

	// Tick output mirrors the counter event one cycle later
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			tick_o <= 1'b0;
		else
			tick_o <= tick_ev;
	end

	// ----------------------------------------------------------------
	// Interrupt
	// ----------------------------------------------------------------
	// Sticky tick status, write one to clear; a new tick wins
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			int_stat_r <= 1'b0;
			int_mask_r <= 1'b0;
		end else begin
			if (tick_ev)
				int_stat_r <= 1'b1;
			else if (wr_en && hit_ist && pwdata_i[`PTK_INT_TICK])
				int_stat_r <= 1'b0;
			if (wr_en && hit_imsk)
				int_mask_r <= pwdata_i[`PTK_INT_TICK];
		end
	end

	// Level interrupt from registered status and mask
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= int_stat_r && int_mask_r;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	// Register access, modulation, tick period, interrupt and lock flag
	a_mod_write_gate: assert property (wr_en && hit_mod && (ctrl_r[`PTK_CTRL_GUARD]
		|| !ctrl_r[`PTK_CTRL_LOOP]) |=> $stable(mod_r))
		else $error("gated modulation write changed the register");
	a_mod_status_clear: assert property (mod_accept && !lock_acquired_i && !crystal_up_i
		|=> !loop_locked_o && !crystal_ready_flag_o)
		else $error("accepted modulation write left a flag set");
	a_mod_read_zero: assert property (psel_i && penable_i && !pready_o && !pwrite_i
		&& hit_mod |=> prdata_o[7:6] == 2'h0 && prdata_o[3:0] == 4'h0
		&& prdata_o[`PTK_MOD_HI:`PTK_MOD_LO] == $past(mod_r))
		else $error("unimplemented modulation bits read non-zero");
	a_fm_off_quiet: assert property (mod_r == 2'h0 |=> !fm_step_o)
		else $error("modulation step while modulation off");
	a_rate_restart: assert property (wr_en && hit_rate |=> count == '0)
		else $error("tick rate write did not restart the period");
	a_src_restart: assert property (src_sel != $past(src_sel) |=> count == '0)
		else $error("source change did not restart the period");
	a_stop_freeze: assert property (!run && !restart && period_en
		|=> $stable(count) && !tick_ev)
		else $error("tick counter moved while frozen in stop");
	a_binary_off: assert property (!rate_r[`PTK_RATE_STYLE]
		&& rate_r[`PTK_RATE_PRE_HI:`PTK_RATE_PRE_LO] == 3'h0 |=> count == '0 && !tick_ev)
		else $error("tick ran with binary code zero");
	a_tick_wrap: assert property (tick_ev |-> count == '0 ##1 tick_o)
		else $error("tick event without counter wrap");
	a_irq_level: assert property (int_stat_r && int_mask_r |=> irq_o)
		else $error("unmasked status did not raise interrupt");
	a_irq_quiet: assert property (!(int_stat_r && int_mask_r) |=> !irq_o)
		else $error("interrupt raised without unmasked status");
	a_lock_set_wins: assert property (lock_acquired_i |=> loop_locked_o)
		else $error("lock event lost against a clear");

	// Bus answer: ready stands one cycle, unmapped addresses are refused
	a_ready_one_cycle: assert property (pready_o |=> !pready_o)
		else $error("ready held longer than one cycle");
	a_unmapped_error: assert property (psel_i && penable_i && !pready_o && !mapped
		|=> pready_o && pslverr_o)
		else $error("unmapped access answered without error");
	a_rate_write_any: assert property (wr_en && hit_rate
		|=> rate_r == $past(pwdata_i[`PTK_RATE_STYLE:`PTK_RATE_MOD_LO]))
		else $error("tick rate write was not taken");

	// Modulation output and pacing
	a_amp_follow: assert property (mod_accept
		|=> ##1 mod_amplitude_o == $past(pwdata_i[`PTK_MOD_HI:`PTK_MOD_LO], 2))
		else $error("amplitude output does not follow the written code");
	a_fm_ref_paced: assert property (fm_step_o |-> $past(ref_edge_i))
		else $error("modulation step without a reference edge");

	// Tick source: the counter moves only on an edge of the selected clock,
	// and a lost crystal drops the crystal source at once
	a_src_needs_ready: assert property (!crystal_ready_flag_o |=> !src_sel)
		else $error("crystal source kept without ready flag");
	a_rc_only_count: assert property (!src_sel && !irc_edge_i
		&& !restart && period_en |=> $stable(count))
		else $error("tick counter moved without an rc clock edge");
	a_xtal_only_count: assert property (src_sel && !xtal_edge_i
		&& !restart && period_en |=> $stable(count))
		else $error("tick counter moved without a crystal edge");
	a_decimal_on: assert property (rate_r[`PTK_RATE_STYLE] |-> period_en)
		else $error("decimal style turned the tick off");

	// Main scenarios reached
	c_mod_accept: cover property (mod_accept ##1 mod_r != 2'h0);
	c_tick_event: cover property (tick_ev);
	c_pseudo_run: cover property (stop_mode_i && run && tick_ev);
	c_src_change: cover property (src_sel && !crystal_ready_flag_o);
	c_full_stop_hold: cover property (stop_mode_i && !run && count != '0);
endmodule // ptk_top

// *** dv/testbench.sv ***
// Self-checking testbench for the periodic tick and loop modulation control
`timescale 1ns/1ps

module testbench;
	// ----------------------------------------------------------------
	// Signals and counters
	// ----------------------------------------------------------------
	logic        mclk_i          = 1'b0;
	logic        reset_n_i       = 1'b0;
	logic        psel_i          = 1'b0;
	logic        penable_i       = 1'b0;
	logic        pwrite_i        = 1'b0;
	logic [7:0]  paddr_i         = 8'h00;
	logic [31:0] pwdata_i        = 32'h00000000;
	logic        irc_edge_i      = 1'b0;
	logic        xtal_edge_i     = 1'b0;
	logic        ref_edge_i      = 1'b0;
	logic        stop_mode_i     = 1'b0;
	logic        lock_acquired_i = 1'b0;
	logic        crystal_up_i    = 1'b0;
	logic        crystal_lost_i  = 1'b0;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic [1:0]  mod_amplitude_o;
	logic        fm_step_o;
	logic        tick_o;
	logic        irq_o;
	logic        loop_locked_o;
	logic        crystal_ready_flag_o;
	logic [31:0] rd;
	logic        err;
	int          errors    = 0;
	int          tests_run = 0;
	int          n_tick    = 0;
	int          n_fm      = 0;

	// Byte addresses: four times the register index
	localparam logic [7:0] A_MOD  = 8'h28;
	localparam logic [7:0] A_RATE = 8'h2C;
	localparam logic [7:0] A_CTRL = 8'h40;
	localparam logic [7:0] A_STAT = 8'h44;
	localparam logic [7:0] A_IST  = 8'h48;
	localparam logic [7:0] A_IMSK = 8'h4C;

	// 40 MHz clock
	always #12.5 mclk_i = ~mclk_i;

	ptk_top ptk_top_inst (
		.mclk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .irc_edge_i, .xtal_edge_i, .ref_edge_i,
		.stop_mode_i, .lock_acquired_i, .crystal_up_i, .crystal_lost_i,
		.mod_amplitude_o, .fm_step_o, .tick_o, .irq_o, .loop_locked_o,
		.crystal_ready_flag_o
	);

	// Pulse counters sample mid-cycle, away from the edge at which tasks clear them
	always @(negedge mclk_i) begin
		if (tick_o === 1'b1) n_tick++;
		if (fm_step_o === 1'b1) n_fm++;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic wrap_up;
		if (errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk_i);
		psel_i   <= 1'b1;
		pwrite_i <= wr;
		paddr_i  <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge mclk_i);
			if (pready_o === 1'b1) break;
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		if (i == 20) begin
			errors++;
			$display("[FAIL] %0t no ready from the register bus", $time);
			wrap_up();
		end
	endtask

	// Pulses one input n times, one cycle high and one low; 0 rc, 1 crystal,
	// 2 reference, 3 lock, 4 crystal up, 5 crystal lost
	task automatic edges(input int n, input int k);
		n_tick = 0;
		n_fm = 0;
		repeat (n) begin
			@(posedge mclk_i);
			{irc_edge_i, xtal_edge_i, ref_edge_i, lock_acquired_i, crystal_up_i,
				crystal_lost_i} <= 6'h20 >> k;
			@(posedge mclk_i);
			{irc_edge_i, xtal_edge_i, ref_edge_i, lock_acquired_i, crystal_up_i,
				crystal_lost_i} <= 6'h00;
		end
		repeat (4) @(posedge mclk_i);
	endtask

	// Writes a rate and checks that the tick comes at exactly p source edges
	task automatic per(input logic [7:0] rate, input int p, input int k);
		apb(1'b1, A_RATE, {24'h000000, rate});
		edges(p - 1, k);
		chk(n_tick, 0, "tick came early");
		edges(1, k);
		chk(n_tick, 1, "tick missing at period end");
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		apb(1'b0, A_MOD, 32'h00000000);
		chk(rd, 32'h00000000, "modulation reset value");
		apb(1'b0, A_RATE, 32'h00000000);
		chk(rd, 32'h00000000, "tick rate reset value");
		apb(1'b0, 8'h3C, 32'h00000000);
		chk({err, rd[30:0]}, 32'h80000000, "unmapped read not refused");
	endtask

	task automatic t_mod;
		int c;
		apb(1'b1, A_MOD, 32'h00000030);
		apb(1'b0, A_MOD, 32'h00000000);
		chk(rd, 32'h00000000, "write taken without loop select");
		apb(1'b1, A_CTRL, 32'h00000008);
		apb(1'b1, A_MOD, 32'hFFFFFFFF);
		apb(1'b0, A_MOD, 32'h00000000);
		chk(rd, 32'h00000030, "only bits 5 and 4 exist");
		for (c = 0; c < 4; c++) begin
			apb(1'b1, A_MOD, 32'(c << 4));
			apb(1'b0, A_MOD, 32'h00000000);
			chk({30'h0, mod_amplitude_o}, 32'(c), "amplitude code");
		end
		apb(1'b1, A_CTRL, 32'h0000000C);
		apb(1'b1, A_MOD, 32'h00000010);
		apb(1'b0, A_MOD, 32'h00000000);
		chk(rd, 32'h00000030, "write taken while protected");
	endtask

	task automatic t_flags;
		edges(1, 3);
		edges(1, 4);
		apb(1'b0, A_STAT, 32'h00000000);
		chk(rd, 32'h00000003, "flags not set");
		apb(1'b1, A_MOD, 32'h00000000);
		apb(1'b0, A_STAT, 32'h00000000);
		chk(rd, 32'h00000003, "refused write cleared flags");
		apb(1'b1, A_CTRL, 32'h00000008);
		apb(1'b1, A_MOD, 32'h00000000);
		apb(1'b0, A_STAT, 32'h00000000);
		chk(rd, 32'h00000000, "flags survive accepted write");
		chk({30'h0, loop_locked_o, crystal_ready_flag_o}, 32'h0, "flag outputs");
	endtask

	task automatic t_fm;
		// Smallest amplitude, so the loop setting keeps the bus below its maximum
		apb(1'b1, A_MOD, 32'h00000010);
		edges(32, 2);
		chk(n_fm, 2, "modulation steps per 32 reference edges");
		apb(1'b1, A_MOD, 32'h00000000);
		edges(32, 2);
		chk(n_fm, 0, "modulation steps while off");
	endtask

	task automatic t_tick;
		per(8'h10, 1024, 0);
		per(8'h20, 2048, 0);
		per(8'h30, 4096, 0);
		per(8'h12, 3072, 0);
		per(8'h80, 1000, 0);
		per(8'h81, 2000, 0);
		apb(1'b1, A_RATE, 32'h0000000F);
		edges(3000, 0);
		chk(n_tick, 0, "tick with binary code zero");
		apb(1'b1, A_RATE, 32'h00000010);
		edges(1000, 0);
		per(8'h10, 1024, 0);
	endtask

	task automatic t_irq;
		apb(1'b1, A_IST, 32'h00000001);
		apb(1'b1, A_IMSK, 32'h00000001);
		per(8'h10, 1024, 0);
		chk({31'h0, irq_o}, 32'h1, "interrupt not raised");
		apb(1'b0, A_IST, 32'h00000000);
		chk(rd, 32'h00000001, "tick status not set");
		apb(1'b1, A_IMSK, 32'h00000000);
		repeat (2) @(posedge mclk_i);
		chk({31'h0, irq_o}, 32'h0, "masked interrupt seen");
		apb(1'b1, A_IMSK, 32'h00000001);
		apb(1'b1, A_IST, 32'h00000001);
		repeat (2) @(posedge mclk_i);
		chk({31'h0, irq_o}, 32'h0, "interrupt not cleared");
	endtask

	task automatic t_source;
		edges(1, 4);
		apb(1'b1, A_CTRL, 32'h00000001);
		apb(1'b0, A_CTRL, 32'h00000000);
		chk(rd, 32'h00000001, "crystal source not selected");
		apb(1'b1, A_RATE, 32'h00000010);
		edges(1100, 0);
		chk(n_tick, 0, "rc edges counted on crystal source");
		edges(1000, 1);
		edges(1, 5);
		apb(1'b0, A_CTRL, 32'h00000000);
		chk(rd, 32'h00000000, "select kept after crystal loss");
		edges(1023, 0);
		chk(n_tick, 0, "period not restarted on source change");
		edges(1, 0);
		chk(n_tick, 1, "rc tick missing after source change");
	endtask

	task automatic t_stop;
		apb(1'b1, A_RATE, 32'h00000010);
		@(posedge mclk_i);
		stop_mode_i <= 1'b1;
		edges(1100, 0);
		chk(n_tick, 0, "rc tick ran in stop");
		edges(1, 4);
		apb(1'b1, A_CTRL, 32'h00000003);
		per(8'h10, 1024, 1);
		apb(1'b1, A_RATE, 32'h00000010);
		edges(500, 1);
		apb(1'b1, A_CTRL, 32'h00000001);
		edges(1100, 1);
		chk(n_tick, 0, "crystal tick ran in full stop");
		stop_mode_i <= 1'b0;
		edges(523, 1);
		chk(n_tick, 0, "frozen count lost or tick early after stop");
		edges(1, 1);
		chk(n_tick, 1, "tick missing where the frozen period ends");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_mod();
		t_flags();
		t_fm();
		t_tick();
		t_irq();
		t_source();
		t_stop();
		wrap_up();
	end
endmodule // testbench
